// File: asr_device.sv
// converter end of the serial readout port
`timescale 1ns/10ps
module asr_device #(
    parameter int unsigned OSC_CYC    = asr_pkg::OSC_CYC_DEF,    // ref cycles per oscillator period
    parameter int unsigned CONV_TICKS = asr_pkg::CONV_TICKS_DEF, // conversion length in clock periods
    parameter int unsigned EXT_MISS   = asr_pkg::EXT_MISS_CYC    // cycles without edge before fallback
) (
    input  wire logic                          ref_clk,                // 250 MHz clock
    input  wire logic                          sys_rst,                // async reset, high
    asr_link_if.dev                            link,                   // serial pins
    input  wire logic                          rejection_select_clock, // level or external clock
    input  wire logic [asr_pkg::WORD_W-1:0]    conv_result,            // result of the running conversion
    output logic                               conv_busy,              // conversion in progress
    output logic                               int_sck_mode,           // device makes sck
    output logic                               ext_conv_clk,           // external conversion clock found
    output asr_pkg::asr_state_e                dev_state               // convert, sleep or output
);
    import asr_pkg::*;

    // ====================================================================
    // state
    asr_state_e           st_r,      st_nxt;
    logic [2:0]           s1_r,      s2_r,       s3_r;
    logic [2:0]           filt_r,    filt_nxt;
    logic [2:0]           prev_r;
    logic [2:0]           por_r,     por_nxt;
    logic                 mode_r,    mode_nxt;
    logic                 ext_r,     ext_nxt;
    logic [31:0]          miss_r,    miss_nxt;
    logic [31:0]          osc_r,     osc_nxt;
    logic [31:0]          conv_r,    conv_nxt;
    logic [1:0]           div_r,     div_nxt;
    logic [BIT_CNT_W-1:0] bit_r,     bit_nxt;
    logic [WORD_W-1:0]    shift_r,   shift_nxt;
    logic                 sck_r,     sck_nxt;
    logic                 sck_oe_r,  sck_oe_nxt;
    logic                 sdo_r,     sdo_nxt;
    logic                 sdo_oe_r,  sdo_oe_nxt;
    logic                 busy_r,    busy_nxt;

    logic cs_low, cs_fall, cs_rise, sck_rise, sck_fall, rsc_rise, tick;

    // ====================================================================
    // next-state logic
    always_comb begin
        // change counts once two stages agree
        filt_nxt = filt_r;
        for (int i = 0; i < 3; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                filt_nxt[i] = s3_r[i];
            end
        end
        cs_low   = ~filt_r[I_CS];
        cs_fall  = prev_r[I_CS] & ~filt_r[I_CS];
        cs_rise  = ~prev_r[I_CS] & filt_r[I_CS];
        sck_rise = ~prev_r[I_SCK] & filt_r[I_SCK];
        sck_fall = prev_r[I_SCK] & ~filt_r[I_SCK];
        rsc_rise = ~prev_r[I_RSC] & filt_r[I_RSC];

        // edges on the select pin mean an external clock
        ext_nxt  = ext_r;
        miss_nxt = miss_r;
        if (rsc_rise) begin
            ext_nxt  = 1'b1;
            miss_nxt = '0;
        end else if (miss_r >= EXT_MISS - 1) begin
            ext_nxt = 1'b0;
        end else begin
            miss_nxt = miss_r + 32'h1;
        end
        // oscillator stays parked while the external clock is in use
        if (ext_r || osc_r == OSC_CYC - 1) begin
            osc_nxt = '0;
        end else begin
            osc_nxt = osc_r + 32'h1;
        end
        tick = ext_r ? rsc_rise : (osc_r == OSC_CYC - 1);

        // strap at reset release, then again at every cs fall
        por_nxt  = (por_r == POR_END) ? por_r : por_r + 3'h1;
        mode_nxt = mode_r;
        if (por_r == POR_CAP || cs_fall) begin
            mode_nxt = filt_r[I_SCK];
        end

        st_nxt    = st_r;
        conv_nxt  = conv_r;
        div_nxt   = div_r;
        bit_nxt   = bit_r;
        shift_nxt = shift_r;
        sck_nxt   = sck_r;
        unique case (st_r)
            ASR_CONVERT: begin
                sck_nxt = 1'b1;
                if (tick) begin
                    if (conv_r == CONV_TICKS - 1) begin
                        // done means sleep, whatever cs does
                        st_nxt   = ASR_SLEEP;
                        conv_nxt = '0;
                        // result captured as the flag falls; top bit carries the flag
                        shift_nxt = {1'b0, conv_result[WORD_W-2:0]};
                    end else begin
                        conv_nxt = conv_r + 32'h1;
                    end
                end
            end
            ASR_SLEEP: begin
                bit_nxt = '0;
                if (mode_r) begin
                    // internal sck: pull low, then first rise after half a period
                    sck_nxt = 1'b0;
                    if (!cs_low) begin
                        div_nxt = '0;
                    end else if (tick) begin
                        div_nxt = div_r + 2'h1;
                        if (div_r == 2'(SCK_HALF - 1)) begin
                            // own first rising edge opens the output state
                            st_nxt  = ASR_OUTPUT;
                            sck_nxt = 1'b1;
                            bit_nxt = BIT_CNT_W'(1);
                            div_nxt = '0;
                        end
                    end
                end else if (cs_low && sck_rise) begin
                    // wake on first external rise with cs low
                    st_nxt = ASR_OUTPUT;
                end
            end
            ASR_OUTPUT: begin
                if (cs_rise) begin
                    // abort the readout and restart conversion
                    st_nxt  = ASR_CONVERT;
                    sck_nxt = 1'b1;
                end else if (mode_r) begin
                    if (tick) begin
                        div_nxt = div_r + 2'h1;
                        if (div_r == 2'(SCK_HALF - 1)) begin
                            // half period of four conversion clocks
                            div_nxt = '0;
                            sck_nxt = ~sck_r;
                            if (sck_r) begin
                                // next bit on the falling edge
                                shift_nxt = {shift_r[WORD_W-2:0], 1'b0};
                            end else if (bit_r == BIT_CNT_W'(WORD_W - 1)) begin
                                // 32nd rise ends output, sck stays high
                                st_nxt = ASR_CONVERT;
                            end else begin
                                bit_nxt = bit_r + BIT_CNT_W'(1);
                            end
                        end
                    end
                end else if (sck_fall) begin
                    // next bit on the falling edge
                    shift_nxt = {shift_r[WORD_W-2:0], 1'b0};
                    bit_nxt   = bit_r + BIT_CNT_W'(1);
                    if (bit_r == BIT_CNT_W'(WORD_W - 1)) begin
                        st_nxt = ASR_CONVERT;
                    end
                end
            end
            default: begin
                st_nxt = ASR_CONVERT;
            end
        endcase

        // sdo only driven with cs low
        sdo_oe_nxt = ~filt_nxt[I_CS];
        sck_oe_nxt = ~filt_nxt[I_CS] & mode_nxt;
        // flag high converting, low asleep; cs low with external sck idle keeps it asleep
        unique case (st_nxt)
            ASR_CONVERT: sdo_nxt = 1'b1;
            ASR_SLEEP:   sdo_nxt = 1'b0;
            ASR_OUTPUT:  sdo_nxt = shift_nxt[WORD_W-1];
            default:     sdo_nxt = 1'b1;
        endcase
        busy_nxt = (st_nxt == ASR_CONVERT);
    end

    // ====================================================================
    // registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r     <= ASR_CONVERT;
            s1_r     <= PIN_RST;
            s2_r     <= PIN_RST;
            s3_r     <= PIN_RST;
            filt_r   <= PIN_RST;
            prev_r   <= PIN_RST;
            por_r    <= '0;
            mode_r   <= 1'b1;
            ext_r    <= 1'b0;
            miss_r   <= '0;
            osc_r    <= '0;
            conv_r   <= '0;
            div_r    <= '0;
            bit_r    <= '0;
            shift_r  <= '0;
            sck_r    <= 1'b1;
            sck_oe_r <= 1'b0;
            sdo_r    <= 1'b1;
            sdo_oe_r <= 1'b0;
            busy_r   <= 1'b1;
        end else begin
            st_r     <= st_nxt;
            s1_r     <= {rejection_select_clock, link.sck, link.cs_n};
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            filt_r   <= filt_nxt;
            prev_r   <= filt_r;
            por_r    <= por_nxt;
            mode_r   <= mode_nxt;
            ext_r    <= ext_nxt;
            miss_r   <= miss_nxt;
            osc_r    <= osc_nxt;
            conv_r   <= conv_nxt;
            div_r    <= div_nxt;
            bit_r    <= bit_nxt;
            shift_r  <= shift_nxt;
            sck_r    <= sck_nxt;
            sck_oe_r <= sck_oe_nxt;
            sdo_r    <= sdo_nxt;
            sdo_oe_r <= sdo_oe_nxt;
            busy_r   <= busy_nxt;
        end
    end

    // ====================================================================
    // outputs
    assign link.dev_sck_o  = sck_r;
    assign link.dev_sck_oe = sck_oe_r;
    assign link.dev_sdo_o  = sdo_r;
    assign link.dev_sdo_oe = sdo_oe_r;
    assign conv_busy       = busy_r;
    assign int_sck_mode    = mode_r;
    assign ext_conv_clk    = ext_r;
    assign dev_state       = st_r;
endmodule

// File: asr_pkg.sv
// shared constants and types for the serial readout port
package asr_pkg;
    localparam int unsigned WORD_W       = 32;      // bits per readout, first one is the done flag
    localparam int unsigned BIT_CNT_W    = 6;
    localparam int unsigned SCK_DIV      = 8;       // internal serial clock = conversion clock / 8
    localparam int unsigned SCK_HALF     = SCK_DIV / 2;
    localparam int unsigned CONV_TICKS_DEF = 20480; // conversion clock periods per conversion
    localparam int unsigned OSC_CYC_DEF  = 1628;    // ref_clk cycles per internal oscillator period
    localparam int unsigned CLK_PERIOD_NS = 4;      // ref_clk period
    localparam int unsigned EXT_MIN_HZ   = 2560;    // slowest conversion clock still detected
    localparam int unsigned EXT_MAX_NS   = 1000000000 / EXT_MIN_HZ;
    localparam int unsigned EXT_MISS_CYC = EXT_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned HOST_HALF_DEF = 16;     // host sck half period in ref_clk cycles
    localparam int unsigned HOST_HALF_MIN = 12;     // below this the pin filters eat the data
    // index of each pin inside the device synchroniser vector
    localparam int unsigned I_CS  = 0;
    localparam int unsigned I_SCK = 1;
    localparam int unsigned I_RSC = 2;
    localparam logic [2:0] PIN_RST  = 3'h3;         // cs high, sck pulled high, select clock low
    localparam logic [2:0] POR_CAP  = 3'h4;         // filter settled, strap the sck level here
    localparam logic [2:0] POR_END  = 3'h5;

    typedef enum logic [1:0] {
        ASR_CONVERT,
        ASR_SLEEP,
        ASR_OUTPUT
    } asr_state_e;

    typedef enum logic [2:0] {
        ASR_H_IDLE,
        ASR_H_SETTLE,
        ASR_H_WAIT_EOC,
        ASR_H_LOW,
        ASR_H_HIGH,
        ASR_H_GAP
    } asr_hstate_e;
endpackage

// File: asr_link_if.sv
// three-wire link between the converter end and the host end
`timescale 1ns/10ps
interface asr_link_if;
    logic cs_n;        // chip select, host drives
    logic host_sck_o;  // host sck drive value
    logic host_sck_oe; // host drives sck
    logic dev_sck_o;   // device sck drive value
    logic dev_sck_oe;  // device drives sck
    logic dev_sdo_o;   // device data drive value
    logic dev_sdo_oe;  // device drives sdo
    logic sck;         // resolved sck wire
    logic sdo;         // resolved sdo wire

    // undriven sck floats high through the pull-up; undriven sdo reads high as well
    assign sck = dev_sck_oe ? dev_sck_o : (host_sck_oe ? host_sck_o : 1'b1);
    assign sdo = dev_sdo_oe ? dev_sdo_o : 1'b1;

    modport dev (
        input  cs_n,
        input  sck,
        output dev_sck_o,
        output dev_sck_oe,
        output dev_sdo_o,
        output dev_sdo_oe
    );
    modport host (
        output cs_n,
        output host_sck_o,
        output host_sck_oe,
        input  sck,
        input  sdo,
        input  dev_sdo_oe
    );
endinterface

// File: asr_host.sv
// host end of the serial readout port: external sck, single cycle reads
`timescale 1ns/10ps
module asr_host #(
    parameter int unsigned HALF_CYC = asr_pkg::HOST_HALF_DEF // sck half period, at least HOST_HALF_MIN
) (
    input  wire logic                       ref_clk,   // 250 MHz clock
    input  wire logic                       sys_rst,   // async reset, high
    asr_link_if.host                        link,      // serial pins
    input  wire logic                       start,     // request one read, pulse
    output logic                            start_rdy, // a read may be requested when busy is also low
    output logic                            busy,      // read in progress
    output logic                            out_valid, // word available
    input  wire logic                       out_ready, // consumer takes word
    output logic [asr_pkg::WORD_W-1:0]      out_data   // flag in top bit, result below
);
    import asr_pkg::*;

    // ====================================================================
    // state
    asr_hstate_e          st_r,   st_nxt;
    logic                 s1_r,   s2_r,   s3_r;
    logic                 sdo_r,  sdo_nxt;
    logic [31:0]          cnt_r,  cnt_nxt;
    logic [BIT_CNT_W-1:0] bit_r,  bit_nxt;
    logic [WORD_W-1:0]    word_r, word_nxt;
    logic                 cs_r,   cs_nxt;
    logic                 sck_r,  sck_nxt;
    logic [WORD_W-1:0]    hd_r,   hd_nxt,  tl_r, tl_nxt;
    logic                 hv_r,   hv_nxt,  tv_r, tv_nxt;
    logic                 busy_r, busy_nxt;
    logic                 rdy_r;
    logic                 push, half_done;

    // ====================================================================
    // next-state logic
    always_comb begin
        sdo_nxt   = (s2_r == s3_r) ? s3_r : sdo_r;
        half_done = (cnt_r == HALF_CYC - 1);
        cnt_nxt   = half_done ? '0 : cnt_r + 32'h1;
        st_nxt    = st_r;
        bit_nxt   = bit_r;
        word_nxt  = word_r;
        cs_nxt    = cs_r;
        sck_nxt   = sck_r;
        push      = 1'b0;
        unique case (st_r)
            ASR_H_IDLE: begin
                cnt_nxt = '0;
                // a read starts only with a free buffer slot, so its word is never dropped
                if (start && !tv_r) begin
                    // sck already low as cs falls
                    st_nxt = ASR_H_SETTLE;
                    cs_nxt = 1'b0;
                end
            end
            ASR_H_SETTLE: begin
                if (half_done) begin
                    st_nxt = ASR_H_WAIT_EOC;
                end
            end
            ASR_H_WAIT_EOC: begin
                cnt_nxt = '0;
                bit_nxt = '0;
                if (!sdo_r) begin
                    st_nxt = ASR_H_LOW;
                end
            end
            ASR_H_LOW: begin
                if (half_done) begin
                    st_nxt  = ASR_H_HIGH;
                    sck_nxt = 1'b1;
                    // sample on the rising edge; first one is the flag
                    word_nxt = {word_r[WORD_W-2:0], sdo_r};
                    bit_nxt  = bit_r + BIT_CNT_W'(1);
                end
            end
            ASR_H_HIGH: begin
                if (half_done) begin
                    sck_nxt = 1'b0;
                    // the 32nd fall restarts conversion in the device
                    if (bit_r == BIT_CNT_W'(WORD_W)) begin
                        st_nxt = ASR_H_GAP;
                        push   = 1'b1;
                    end else begin
                        st_nxt = ASR_H_LOW;
                    end
                end
            end
            ASR_H_GAP: begin
                // release cs after the word to free sdo
                if (half_done) begin
                    cs_nxt = 1'b1;
                    st_nxt = ASR_H_IDLE;
                end
            end
            default: begin
                st_nxt = ASR_H_IDLE;
                cs_nxt = 1'b1;
            end
        endcase
        busy_nxt = (st_nxt != ASR_H_IDLE);

        // two-entry buffer: head feeds the consumer, tail catches a word during a stall
        hd_nxt = hd_r;
        hv_nxt = hv_r;
        tl_nxt = tl_r;
        tv_nxt = tv_r;
        if (hv_r && out_ready) begin
            hd_nxt = tl_r;
            hv_nxt = tv_r;
            tv_nxt = 1'b0;
        end
        if (push) begin
            if (!hv_nxt) begin
                hd_nxt = word_nxt;
                hv_nxt = 1'b1;
            end else begin
                tl_nxt = word_nxt;
                tv_nxt = 1'b1;
            end
        end
    end

    // ====================================================================
    // registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r   <= ASR_H_IDLE;
            s1_r   <= 1'b1;
            s2_r   <= 1'b1;
            s3_r   <= 1'b1;
            sdo_r  <= 1'b1;
            cnt_r  <= '0;
            bit_r  <= '0;
            word_r <= '0;
            cs_r   <= 1'b1;
            sck_r  <= 1'b0;
            hd_r   <= '0;
            hv_r   <= 1'b0;
            tl_r   <= '0;
            tv_r   <= 1'b0;
            busy_r <= 1'b0;
            rdy_r  <= 1'b1;
        end else begin
            st_r   <= st_nxt;
            s1_r   <= link.sdo;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            sdo_r  <= sdo_nxt;
            cnt_r  <= cnt_nxt;
            bit_r  <= bit_nxt;
            word_r <= word_nxt;
            cs_r   <= cs_nxt;
            sck_r  <= sck_nxt;
            hd_r   <= hd_nxt;
            hv_r   <= hv_nxt;
            tl_r   <= tl_nxt;
            tv_r   <= tv_nxt;
            busy_r <= busy_nxt;
            rdy_r  <= ~tv_nxt;
        end
    end

    // ====================================================================
    // outputs
    // sck driven low from reset on, so the strap picks external mode
    assign link.host_sck_oe = 1'b1;
    assign link.host_sck_o  = sck_r;
    assign link.cs_n        = cs_r;
    assign start_rdy        = rdy_r;
    assign busy             = busy_r;
    assign out_valid        = hv_r;
    assign out_data         = hd_r;
endmodule

// File: asr_link_monitor.sv
// assertions on the three-wire link between host end and converter end
`timescale 1ns/10ps
module asr_link_monitor (
    input wire logic ref_clk,    // clock
    input wire logic sys_rst,    // async reset, high
    input wire logic cs_n,       // chip select
    input wire logic sck,        // resolved sck
    input wire logic sdo,        // resolved sdo
    input wire logic dev_sdo_oe, // device drives sdo
    input wire logic dev_sck_oe  // device drives sck
);
    logic [5:0] fall_cnt_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ======================================================
    // sck falls seen since chip select went low
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fall_cnt_r <= 6'h00;
        end else if (cs_n) begin
            fall_cnt_r <= 6'h00;
        end else if ($fell(sck)) begin
            fall_cnt_r <= fall_cnt_r + 6'h01;
        end
    end

    // ======================================================
    // link properties; pin filters delay the device by about five cycles
    property p_sdo_float; cs_n [*8] |-> !dev_sdo_oe; endproperty
    a_sdo_float: assert property (p_sdo_float) else $error("sdo driven while deselected");
    property p_sdo_drive; (!cs_n) [*8] |-> dev_sdo_oe; endproperty
    a_sdo_drive: assert property (p_sdo_drive) else $error("sdo not driven while selected");
    property p_ext_mode; !dev_sck_oe; endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("device drove sck in external mode");
    property p_hold_high; (!cs_n && sck) [*8] |=> $stable(sdo); endproperty
    a_hold_high: assert property (p_hold_high) else $error("sdo moved while sck high");
    property p_cs_fall; $fell(cs_n) |-> !sck; endproperty
    a_cs_fall: assert property (p_cs_fall) else $error("cs fell with sck high");
    property p_flag_first; $rose(sck) && fall_cnt_r == 6'h00 |-> !sdo; endproperty
    a_flag_first: assert property (p_flag_first) else $error("first rise without done flag low");
    property p_new_conv; $fell(sck) && fall_cnt_r == 6'h1f |-> ##[8:12] (dev_sdo_oe && sdo); endproperty
    a_new_conv: assert property (p_new_conv) else $error("sdo not high after last fall");
    property p_cs_count; $rose(cs_n) |-> fall_cnt_r == 6'h20; endproperty
    a_cs_count: assert property (p_cs_count) else $error("cs released before full word");
    property p_half; $rose(sck) |-> sck [*8]; endproperty
    a_half: assert property (p_half) else $error("sck high phase too short for filters");
endmodule

// File: test_adc_serial_readout_port.sv
// testbench: host and converter ends joined, plus a bench-driven second converter
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module test_adc_serial_readout_port;
    import asr_pkg::*;
    localparam int unsigned H = 16;
    localparam int unsigned OSC = 2;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        rsc = 1'b0;
    logic        rsc_en = 1'b0;
    logic [31:0] conv_result = 32'h8a5c3e71;
    logic        start = 1'b0;
    logic        out_ready = 1'b0;
    logic        start_rdy, busy, out_valid, conv_busy, int_sck_mode, ext_conv_clk, busy2, mode2;
    logic [31:0] out_data;
    logic [31:0] sh;
    asr_state_e  dev_state, state2;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          i;
    int          n;

    asr_link_if l1 ();
    asr_link_if l2 ();
    asr_link_monitor asr_link_monitor_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(l1.cs_n), .sck(l1.sck),
        .sdo(l1.sdo), .dev_sdo_oe(l1.dev_sdo_oe), .dev_sck_oe(l1.dev_sck_oe));
    asr_device #(.OSC_CYC(OSC), .CONV_TICKS(64), .EXT_MISS(200)) asr_device_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .link(l1.dev), .rejection_select_clock(rsc), .conv_result(conv_result),
        .conv_busy(conv_busy), .int_sck_mode(int_sck_mode), .ext_conv_clk(ext_conv_clk), .dev_state(dev_state));
    asr_host asr_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(l1.host), .start(start),
        .start_rdy(start_rdy), .busy(busy), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
    asr_device #(.OSC_CYC(OSC), .CONV_TICKS(64), .EXT_MISS(200)) asr_device_inst2 (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .link(l2.dev), .rejection_select_clock(1'b0), .conv_result(conv_result),
        .conv_busy(busy2), .int_sck_mode(mode2), .ext_conv_clk(), .dev_state(state2));

    always #2 ref_clk = ~ref_clk;

    // external conversion clock, period 40 cycles, well inside the miss window
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rsc_en && cyc % 20 == 0) rsc <= #1 ~rsc;
    end

    // ======================================================
    // tasks
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic read_word(input logic [31:0] res);
        conv_result = res;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        for (i = 0; i < 9000 && busy === 1'b1; i++) tick(1);
    endtask

    // two reads with the consumer stalled, then drain both slots
    task automatic read_two(input logic [31:0] a, input logic [31:0] b, input logic [31:0] ea,
                            input logic [31:0] eb);
        read_word(a);
        read_word(b);
        `CHK("start_rdy", 1'b0, start_rdy)
        out_ready = 1'b1;
        `CHK("word_a", ea, out_data)
        tick(1);
        `CHK("word_b", eb, out_data)
        tick(1);
        `CHK("drained", 1'b0, out_valid)
        `CHK("host_idle", 1'b0, busy)
        out_ready = 1'b0;
    endtask

    // bench sck on the second link: sample while high, data moves on the fall
    task automatic clk2(input int k);
        repeat (k) begin
            l2.host_sck_o = 1'b1;
            tick(H);
            sh = {sh[30:0], l2.sdo};
            l2.host_sck_o = 1'b0;
            tick(H);
        end
    endtask

    task automatic wait_busy2();
        for (i = 0; i < 3000 && busy2 !== 1'b0; i++) tick(1);
        tick(8);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end

    // ======================================================
    // main sequence
    initial begin
        l2.cs_n = 1'b1;
        l2.host_sck_o = 1'b0;
        l2.host_sck_oe = 1'b1;
        tick(8);
        sys_rst = 1'b0;
        read_two(32'h8a5c3e71, 32'h7135c0f2, 32'h0a5c3e71, 32'h7135c0f2);
        `CHK("int_mode1", 1'b0, int_sck_mode)
        `CHK("busy1", 1'b1, conv_busy)
        `CHK("st1", ASR_CONVERT, dev_state)
        rsc_en = 1'b1;
        tick(200);
        `CHK("ext_clk", 1'b1, ext_conv_clk)
        // the slow external clock stretches the running conversion, so the first word is this call's own result
        read_two(32'h13579bdf, 32'h9bdf1357, 32'h13579bdf, 32'h1bdf1357);
        rsc_en = 1'b0;
        tick(300);
        `CHK("osc_back", 1'b0, ext_conv_clk)
        // second converter slept holding the first result
        conv_result = 32'h2468ace1;
        // sck low at the first two cs falls
        l2.cs_n = 1'b0;
        tick(8);
        `CHK("eoc_sleep", 1'b0, l2.sdo)
        `CHK("st_sleep", ASR_SLEEP, state2)
        clk2(8);
        `CHK("first8", 8'h0a, sh[7:0])
        `CHK("st_out", ASR_OUTPUT, state2)
        l2.cs_n = 1'b1;
        tick(8);
        `CHK("abort", ASR_CONVERT, state2)
        `CHK("sdo_float", 1'b0, l2.dev_sdo_oe)
        l2.cs_n = 1'b0;
        tick(8);
        `CHK("eoc_busy", 1'b1, l2.sdo)
        wait_busy2();
        clk2(32);
        `CHK("full_word", {1'b0, conv_result[30:0]}, sh)
        tick(8);
        `CHK("restart", 1'b1, l2.sdo)
        `CHK("st_conv", ASR_CONVERT, state2)
        wait_busy2();
        `CHK("cont_conv", 1'b0, l2.sdo)
        l2.cs_n = 1'b1;
        tick(8);
        clk2(2);
        `CHK("no_wake", ASR_SLEEP, state2)
        // released sck floats high, so the next cs fall picks internal mode
        l2.host_sck_oe = 1'b0;
        tick(8);
        l2.cs_n = 1'b0;
        tick(8);
        `CHK("int_mode2", 1'b1, mode2)
        for (i = 0; i < 200 && l2.sck !== 1'b0; i++) tick(1);
        for (i = 0; i < 200 && l2.sck !== 1'b1; i++) tick(1);
        for (n = 0; n < 200 && l2.sck !== 1'b0; n++) tick(1);
        for (i = 0; i < 200 && l2.sck !== 1'b1; i++) tick(1);
        n = n + i;
        `CHK("sck_period", 32'(SCK_DIV * OSC), 32'(n))
        test_done();
    end
endmodule
